// ### ipc_core.sv
// Purpose: Operation-phase command, priority and service logic
// Assumes: Strobes are asynchronous levels, synchronized and edge-detected here
// Notes:   Setup words, vector bytes, cascade not included
// Functional notes
// - Eight mask bits, one inhibits input
// - Special mask write enable sets mode
// - Enable zero leaves mask mode unchanged
// - Fully nested, input 0 highest
// - Acknowledge sets highest pending service bit
// - Service bit blocks equal, lower requests
// - Non-specific end clears highest service bit
// - Specific end clears coded service bit
// - Special mask spares masked service bits
// - Auto end at last acknowledge pulse
// - Serviced input rotates to lowest priority
// - Rotate codes on end, auto set/clear
// - Set priority makes coded input lowest
// - Rotate specific end clears and rotates
// - Special mask: only own level inhibited
// - Poll makes next select-low read an acknowledge
// - Requests frozen from poll write to read
// - Poll word flag and level code
// - Service bit stays until end command or auto end
// - Poll overrides status register read
// - Select-line-high read returns mask bits
module ipc_core
  import ipc_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] request_inputs_in,
  input  wire logic       write_strobe_in,
  input  wire logic       read_strobe_in,
  input  wire logic       register_select_line_in,
  input  wire logic [7:0] data_in,
  input  wire logic       acknowledge_strobe_in,
  input  wire logic       auto_end_of_service_in,
  input  wire logic       wide_cpu_mode_in,
  output logic [7:0]      data_out,
  output logic            data_oe_out,
  output logic            int_out,
  output logic [2:0]      vector_level_out
);
  logic [2:0]  req_s1, req_s2, req_s3;
  logic [7:0]  pin_s1, pin_s2, pin_s3;
  logic [7:0]  pending;
  logic [7:0]  frozen_req;
  logic [7:0]  request_mask_bits;
  logic [7:0]  in_service_bits;
  logic [2:0]  lowest;
  logic        special_mask_select;
  logic        rotate_auto;
  logic        poll_armed;
  ipc_rdsel_t  rd_sel;
  logic [2:0]  ack_count;
  logic [2:0]  ack_level;
  logic        ack_d1, ack_d2;
  logic        rd_d1, rd_d2;
  logic        wr_d1, wr_d2;
  logic        ack_start;
  logic        ack_end;
  logic        rd_start;
  logic        wr_start;
  logic        cmd_prio;
  logic        cmd_mode;
  logic        cmd_mask;
  logic        poll_read;
  logic [2:0]  op;
  logic [2:0]  code;
  logic [2:0]  last_ack;
  logic [2:0]  ns_level;
  logic        ns_found;
  logic [7:0]  rd_word;

  ipc_resolve_if rif ();
  ipc_resolver u_res (.rif(rif));

  // Pin inputs: three stages, change on second/third agree
  always_ff @(posedge core_clk_in) begin
    pin_s1 <= request_inputs_in;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    req_s1 <= {acknowledge_strobe_in, read_strobe_in, write_strobe_in};
    req_s2 <= req_s1;
    req_s3 <= req_s2;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pending <= IPC_ZERO8;
      wr_d1 <= 1'b0;
      rd_d1 <= 1'b0;
      ack_d1 <= 1'b0;
    end else begin
      for (int i = 0; i < IPC_LEVELS; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pending[i] <= pin_s3[i];
        end
      end
      if (req_s2[0] == req_s3[0]) begin
        wr_d1 <= req_s3[0];
      end
      if (req_s2[1] == req_s3[1]) begin
        rd_d1 <= req_s3[1];
      end
      if (req_s2[2] == req_s3[2]) begin
        ack_d1 <= req_s3[2];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_d2 <= 1'b0;
      rd_d2 <= 1'b0;
      ack_d2 <= 1'b0;
    end else begin
      wr_d2 <= wr_d1;
      rd_d2 <= rd_d1;
      ack_d2 <= ack_d1;
    end
  end

  assign wr_start  = wr_d1 && !wr_d2;
  assign rd_start  = rd_d1 && !rd_d2;
  assign ack_start = ack_d1 && !ack_d2;
  assign ack_end   = !ack_d1 && ack_d2;

  assign cmd_mask = wr_start && register_select_line_in;
  assign cmd_prio = wr_start && !register_select_line_in
                    && data_in[CW_KIND_HI:CW_KIND_LO] == CW_KIND_PRIO;
  assign cmd_mode = wr_start && !register_select_line_in
                    && data_in[CW_KIND_HI:CW_KIND_LO] == CW_KIND_MODE;
  assign op   = {data_in[CW_ROT_BIT], data_in[CW_SEL_BIT], data_in[CW_EOS_BIT]};
  assign code = data_in[2:0];
  assign poll_read = rd_start && poll_armed && !register_select_line_in;
  assign last_ack  = wide_cpu_mode_in ? ACK_LAST_16BIT : ACK_LAST_8BIT;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      frozen_req <= IPC_ZERO8;
    end else if (!poll_armed) begin
      frozen_req <= pending;
    end
  end

  assign rif.pending = poll_armed ? frozen_req : pending;
  assign rif.serving = in_service_bits;
  assign rif.masks   = request_mask_bits;
  assign rif.lowest  = lowest;
  assign rif.special = special_mask_select;
  assign ns_found = rif.srv_found;
  assign ns_level = rif.srv_level;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      request_mask_bits <= IPC_MASK_RESET;
    end else if (cmd_mask) begin
      request_mask_bits <= data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      special_mask_select <= 1'b0;
    end else if (cmd_mode && data_in[CW_SMW_BIT]) begin
      special_mask_select <= data_in[CW_SMS_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      poll_armed <= 1'b0;
      rd_sel <= IPC_RD_REQ;
    end else if (cmd_mode) begin
      poll_armed <= data_in[CW_POLL_BIT];
      if (data_in[CW_RR_BIT]) begin
        rd_sel <= data_in[CW_RIS_BIT] ? IPC_RD_SERV : IPC_RD_REQ;
      end
    end else if (poll_read) begin
      poll_armed <= 1'b0;
    end
  end

  // Acknowledge pulse counting, level latch
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_count <= 3'h0;
      ack_level <= IPC_HI_LEVEL;
    end else if (ack_start) begin
      ack_count <= 3'(ack_count + 3'h1);
      if (ack_count == 3'h0) begin
        ack_level <= rif.req_found ? rif.req_level : IPC_HI_LEVEL;
      end
    end else if (ack_end && ack_count == last_ack) begin
      ack_count <= 3'h0;
    end
  end

  // Service bits and rotation
  // bits held until end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      in_service_bits <= IPC_ZERO8;
      lowest <= IPC_LOW_RESET;
      rotate_auto <= 1'b0;
    end else if (ack_start && ack_count == 3'h0 && rif.req_found) begin
      in_service_bits[rif.req_level] <= 1'b1;
    end else if (poll_read && rif.req_found) begin
      in_service_bits[rif.req_level] <= 1'b1;
    end else if (ack_end && ack_count == last_ack && auto_end_of_service_in) begin
      if (ns_found) begin
        in_service_bits[ns_level] <= 1'b0;
      end
      if (rotate_auto) begin
        lowest <= ack_level;
      end
    end else if (cmd_prio) begin
      case (op)
        OP_NS_EOS: begin
          if (ns_found) begin
            in_service_bits[ns_level] <= 1'b0;
          end
        end
        OP_SP_EOS: begin
          in_service_bits[code] <= 1'b0;
        end
        OP_ROT_NS_EOS: begin
          if (ns_found) begin
            in_service_bits[ns_level] <= 1'b0;
            lowest <= ns_level;
          end
        end
        OP_ROT_AUTO_SET: begin
          rotate_auto <= 1'b1;
        end
        OP_ROT_AUTO_CLR: begin
          rotate_auto <= 1'b0;
        end
        OP_SET_PRIO: begin
          lowest <= code;
        end
        OP_ROT_SP_EOS: begin
          in_service_bits[code] <= 1'b0;
          lowest <= code;
        end
        default: begin
          lowest <= lowest;
        end
      endcase
    end
  end

  always_comb begin
    if (register_select_line_in) begin
      rd_word = request_mask_bits;
    end else if (poll_armed) begin
      rd_word = IPC_ZERO8;
      rd_word[POLL_FLAG_BIT] = rif.req_found;
      rd_word[2:0] = rif.req_found ? rif.req_level : 3'h0;
    end else if (rd_sel == IPC_RD_SERV) begin
      rd_word = in_service_bits;
    end else begin
      rd_word = pending;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_out <= IPC_ZERO8;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= rd_d1;
      if (rd_start) begin
        data_out <= rd_word;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      int_out <= 1'b0;
      vector_level_out <= IPC_HI_LEVEL;
    end else begin
      int_out <= rif.int_ok && ack_count == 3'h0;
      vector_level_out <= ack_level;
    end
  end

  AST_MASK_BLOCK: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (rif.pending & ~request_mask_bits) == IPC_ZERO8 |=> !int_out)
    else $error("masked request raised interrupt");

  AST_SMM_SET: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_mode && data_in[CW_SMW_BIT] |=> special_mask_select == $past(data_in[CW_SMS_BIT]))
    else $error("special mask mode not updated");

  AST_SMM_KEEP: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_mode && !data_in[CW_SMW_BIT] |=> $stable(special_mask_select))
    else $error("special mask mode changed");

  AST_ACK_SETS: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ack_start && ack_count == 3'h0 && rif.req_found |=> in_service_bits[ack_level])
    else $error("acknowledge did not set service bit");

  AST_SPEC_EOS: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_prio && op == OP_SP_EOS && !ack_start && !poll_read && !ack_end |=> !in_service_bits[$past(code)])
    else $error("specific end did not clear");

  AST_SET_PRIO: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_prio && op == OP_SET_PRIO && !ack_start && !poll_read && !ack_end
    |=> lowest == $past(code) && $stable(in_service_bits))
    else $error("set priority wrong");

  AST_POLL_FREEZE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    poll_armed && $past(poll_armed) |-> $stable(frozen_req))
    else $error("requests not frozen during poll");

  AST_POLL_EMPTY: assert property (@(posedge core_clk_in) disable iff (rst_in)
    poll_read && !rif.req_found && !cmd_prio && !ack_end && !ack_start
    |=> data_out[POLL_FLAG_BIT] == 1'b0 && $stable(in_service_bits))
    else $error("empty poll changed state");

  AST_MASK_READ: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rd_start && register_select_line_in && !cmd_mask |=> data_out == request_mask_bits)
    else $error("mask read wrong");
endmodule : ipc_core

// ### ipc_pkg.sv
// Purpose: Shared constants for the interrupt priority command logic
// Assumes: Byte-wide host port, eight request inputs
// Notes:   Field positions of command words and poll word
package ipc_pkg;
  localparam int          IPC_LEVELS      = 8;
  localparam logic [2:0]  IPC_HI_LEVEL    = 3'h7;
  localparam logic [7:0]  IPC_MASK_RESET  = 8'h00;
  localparam logic [7:0]  IPC_ZERO8       = 8'h00;
  localparam logic [2:0]  IPC_LOW_RESET   = 3'h7;
  localparam int          CW_KIND_HI      = 4;
  localparam int          CW_KIND_LO      = 3;
  localparam logic [1:0]  CW_KIND_PRIO    = 2'h0;
  localparam logic [1:0]  CW_KIND_MODE    = 2'h1;
  localparam int          CW_ROT_BIT      = 7;
  localparam int          CW_SEL_BIT      = 6;
  localparam int          CW_EOS_BIT      = 5;
  localparam int          CW_SMW_BIT      = 6;
  localparam int          CW_SMS_BIT      = 5;
  localparam int          CW_POLL_BIT     = 2;
  localparam int          CW_RR_BIT       = 1;
  localparam int          CW_RIS_BIT      = 0;
  localparam int          POLL_FLAG_BIT   = 7;
  localparam logic [2:0]  OP_NS_EOS       = 3'h1;
  localparam logic [2:0]  OP_SP_EOS       = 3'h3;
  localparam logic [2:0]  OP_ROT_NS_EOS   = 3'h5;
  localparam logic [2:0]  OP_ROT_AUTO_SET = 3'h4;
  localparam logic [2:0]  OP_ROT_AUTO_CLR = 3'h0;
  localparam logic [2:0]  OP_SET_PRIO     = 3'h6;
  localparam logic [2:0]  OP_ROT_SP_EOS   = 3'h7;
  localparam logic [2:0]  ACK_LAST_8BIT   = 3'h3;
  localparam logic [2:0]  ACK_LAST_16BIT  = 3'h2;

  typedef enum logic [1:0] {
    IPC_RD_REQ  = 2'b00,
    IPC_RD_SERV = 2'b01,
    IPC_RD_POLL = 2'b10
  } ipc_rdsel_t;
endpackage : ipc_pkg

// ### ipc_resolve_if.sv
// Purpose: Carries priority resolver inputs and results
// Assumes: One clock domain
// Notes:   Purely combinational results
interface ipc_resolve_if;
  import ipc_pkg::*;
  logic [7:0] pending;
  logic [7:0] serving;
  logic [7:0] masks;
  logic [2:0] lowest;
  logic       special;
  logic       req_found;
  logic [2:0] req_level;
  logic       int_ok;
  logic       srv_found;
  logic [2:0] srv_level;
  modport ctrl (output pending, serving, masks, lowest, special,
                input  req_found, req_level, int_ok, srv_found, srv_level);
  modport res  (input  pending, serving, masks, lowest, special,
                output req_found, req_level, int_ok, srv_found, srv_level);
endinterface : ipc_resolve_if

// ### ipc_resolver.sv
// Purpose: Rotating priority search over request and service bits
// Assumes: Level lowest gets bottom priority, lowest+1 top
// Notes:   Combinational only
module ipc_resolver
  import ipc_pkg::*;
(
  ipc_resolve_if.res rif
);
  // Highest-priority set bit, search from lowest+1 upward
  function automatic logic [3:0] ipc_find(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] idx;
    r = 4'h0;
    for (int k = IPC_LEVELS - 1; k >= 0; k--) begin
      idx = 3'(low + 3'(k) + 3'h1);
      if (v[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction : ipc_find

  logic [3:0] req_hit;
  logic [3:0] srv_hit;
  logic [7:0] srv_eff;
  logic [7:0] req_eff;

  always_comb begin
    req_eff = rif.pending & ~rif.masks;
    srv_eff = rif.special ? (rif.serving & ~rif.masks) : rif.serving;
    req_hit = ipc_find(req_eff, rif.lowest);
    srv_hit = ipc_find(srv_eff, rif.lowest);
  end

  assign rif.req_found = req_hit[3];
  assign rif.req_level = req_hit[2:0];
  assign rif.srv_found = srv_hit[3];
  assign rif.srv_level = srv_hit[2:0];

  always_comb begin
    if (!req_hit[3]) begin
      rif.int_ok = 1'b0;
    end else if (rif.special || !srv_hit[3]) begin
      rif.int_ok = !srv_eff[req_hit[2:0]];
    end else begin
      rif.int_ok = 3'(req_hit[2:0] - rif.lowest - 3'h1) < 3'(srv_hit[2:0] - rif.lowest - 3'h1);
    end
  end
endmodule : ipc_resolver

// ### ipc_host_model.sv
// Purpose: Host processor model driving the command port
// Assumes: Strobes held six clocks high and six low (seven low after a write)
// Notes:   Released data bus shows the inverted last byte
module ipc_host_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] data_out_in,
  input  wire logic       data_oe_in,
  output logic            write_strobe_out,
  output logic            read_strobe_out,
  output logic            register_select_out,
  output logic [7:0]      data_bus_out,
  output logic            ack_strobe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = 6;
  logic          oe_seen;

  initial begin
    write_strobe_out    = 1'b0;
    read_strobe_out     = 1'b0;
    register_select_out = 1'b0;
    data_bus_out        = 8'h00;
    ack_strobe_out      = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : gap

  task automatic write_word(input logic sel, input logic [7:0] val);
    register_select_out = sel;
    data_bus_out        = val;
    write_strobe_out    = 1'b1;
    gap(HOLD);
    write_strobe_out = 1'b0;
    gap(1);
    data_bus_out = ~val;
    gap(HOLD);
  endtask : write_word

  task automatic read_word(input logic sel, output logic [7:0] val);
    register_select_out = sel;
    read_strobe_out     = 1'b1;
    gap(HOLD);
    val             = data_out_in;
    oe_seen         = data_oe_in;
    read_strobe_out = 1'b0;
    gap(HOLD);
  endtask : read_word

  task automatic ack_pulses(input int n);
    repeat (n) begin
      ack_strobe_out = 1'b1;
      gap(HOLD);
      ack_strobe_out = 1'b0;
      gap(HOLD);
    end
  endtask : ack_pulses
endmodule : ipc_host_model

// ### tb_interrupt_priority_command_logic.sv
// Purpose: Self-checking bench for the priority command logic
// Assumes: Single master controller, host model drives strobes
// Notes:   Interrupt output checked after sync settling
module tb_interrupt_priority_command_logic
  import ipc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk;
  logic       rst;
  logic [7:0] req;
  logic       auto_eos;
  logic       wide;
  logic       wr;
  logic       rd;
  logic       sel;
  logic [7:0] dbus;
  logic       ack;
  logic [7:0] dout;
  logic       doe;
  logic       irq;
  logic [2:0] vlev;
  logic [7:0] v;
  int         num_errors = 0;
  int         comparisons = 0;

  ipc_core u_dut (
    .core_clk_in(clk), .rst_in(rst), .request_inputs_in(req),
    .write_strobe_in(wr), .read_strobe_in(rd), .register_select_line_in(sel),
    .data_in(dbus), .acknowledge_strobe_in(ack), .auto_end_of_service_in(auto_eos),
    .wide_cpu_mode_in(wide), .data_out(dout), .data_oe_out(doe), .int_out(irq),
    .vector_level_out(vlev)
  );
  ipc_host_model u_host (
    .core_clk_in(clk), .data_out_in(dout), .data_oe_in(doe), .write_strobe_out(wr),
    .read_strobe_out(rd), .register_select_out(sel), .data_bus_out(dbus),
    .ack_strobe_out(ack)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] prio(input logic [2:0] op, input logic [2:0] lvl);
    return {op, CW_KIND_PRIO, lvl};
  endfunction : prio

  function automatic logic [7:0] mode(input logic smw, input logic sms, input logic p, input logic rr);
    return {1'b0, smw, sms, CW_KIND_MODE, p, rr, 1'b0};
  endfunction : mode

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask : do_reset

  task automatic req_int(input logic [7:0] r, input logic exp);
    req = r;
    u_host.gap(10);
    check_bit("int_out", exp, irq);
  endtask : req_int

  task automatic do_ack(input int n, input logic [2:0] lvl);
    u_host.ack_pulses(n);
    check_byte("vector_level_out", {5'h00, lvl}, {5'h00, vlev});
  endtask : do_ack

  task automatic cmd(input logic [7:0] w);
    u_host.write_word(1'b0, w);
  endtask : cmd

  task automatic poll(input logic rr, input logic [7:0] exp);
    cmd(mode(1'b0, 1'b0, 1'b1, rr));
    u_host.read_word(1'b0, v);
    check_byte("poll_result_word", exp, v & 8'h87);
  endtask : poll

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    rst      = 1'b1;
    req      = 8'h00;
    auto_eos = 1'b0;
    wide     = 1'b0;
    do_reset();
    check_byte("vector_level_out", 8'h07, {5'h00, vlev});
    u_host.read_word(1'b1, v);
    check_byte("request_mask_bits", 8'h00, v);
    check_bit("data_oe_out", 1'b1, u_host.oe_seen);
    check_bit("data_oe_out", 1'b0, doe);
    u_host.write_word(1'b1, 8'hFF);
    u_host.read_word(1'b1, v);
    check_byte("request_mask_bits", 8'hFF, v);
    req_int(8'h08, 1'b0);
    u_host.write_word(1'b1, 8'hF7);
    req_int(8'h08, 1'b1);
    u_host.write_word(1'b1, 8'h00);
    do_ack(3, 3'h3);
    req_int(8'h08, 1'b0);
    req_int(8'h28, 1'b0);
    req_int(8'h0A, 1'b1);
    cmd(prio(OP_NS_EOS, 3'h0));
    req_int(8'h08, 1'b1);
    do_ack(3, 3'h3);
    cmd(prio(OP_SP_EOS, 3'h2));
    req_int(8'h08, 1'b0);
    cmd(prio(OP_SP_EOS, 3'h3));
    req_int(8'h08, 1'b1);
    poll(1'b0, 8'h83);
    req_int(8'h08, 1'b0);
    cmd(prio(OP_NS_EOS, 3'h0));
    poll(1'b1, 8'h83);
    cmd(prio(OP_NS_EOS, 3'h0));
    req = 8'h00;
    cmd(mode(1'b0, 1'b0, 1'b1, 1'b0));
    req = 8'h02;
    u_host.gap(10);
    u_host.read_word(1'b0, v);
    check_byte("poll_result_word", 8'h00, v & 8'h87);
    req_int(8'h02, 1'b1);
    cmd(prio(OP_SET_PRIO, 3'h3));
    req_int(8'h30, 1'b1);
    do_ack(3, 3'h4);
    cmd(8'h0A);
    u_host.read_word(1'b0, v);
    check_byte("pending_requests", 8'h30, v);
    cmd(8'h0B);
    u_host.read_word(1'b0, v);
    check_byte("in_service_bits", 8'h10, v);
    req_int(8'h28, 1'b0);
    cmd(prio(OP_ROT_SP_EOS, 3'h4));
    req_int(8'h30, 1'b1);
    do_ack(3, 3'h5);
    cmd(prio(OP_ROT_NS_EOS, 3'h0));
    req_int(8'h41, 1'b1);
    do_ack(3, 3'h6);
    cmd(prio(OP_NS_EOS, 3'h0));
    auto_eos = 1'b1;
    cmd(prio(OP_ROT_AUTO_SET, 3'h0));
    req_int(8'h01, 1'b1);
    do_ack(3, 3'h0);
    req_int(8'h01, 1'b1);
    req_int(8'h05, 1'b1);
    do_ack(3, 3'h2);
    wide = 1'b1;
    cmd(prio(OP_ROT_AUTO_CLR, 3'h0));
    req_int(8'h21, 1'b1);
    do_ack(2, 3'h5);
    req_int(8'h21, 1'b1);
    auto_eos = 1'b0;
    wide = 1'b0;
    do_reset();
    req_int(8'h06, 1'b1);
    do_ack(3, 3'h1);
    req_int(8'h06, 1'b0);
    u_host.write_word(1'b1, 8'h02);
    cmd(mode(1'b0, 1'b1, 1'b0, 1'b0));
    req_int(8'h06, 1'b0);
    cmd(mode(1'b1, 1'b1, 1'b0, 1'b0));
    req_int(8'h06, 1'b1);
    cmd(prio(OP_NS_EOS, 3'h0));
    cmd(mode(1'b1, 1'b0, 1'b0, 1'b0));
    u_host.write_word(1'b1, 8'h00);
    req_int(8'h04, 1'b0);
    cmd(8'h38);
    req_int(8'h04, 1'b0);
    cmd(prio(OP_NS_EOS, 3'h0));
    req_int(8'h04, 1'b1);
    complete_run();
  end
endmodule : tb_interrupt_priority_command_logic
